// [hw/ppl_cfg.svh]
// Named constants of the per-port preload loader: word addresses, offsets, bit positions.
// Assumes inclusion by bare name from every design file that needs a figure.
`ifndef PPL_CFG_SVH
`define PPL_CFG_SVH

// ------------------------------------------------------------
// Port count and preload word addresses
// ------------------------------------------------------------
`define PPL_NUM_PORTS 3'h6
`define PPL_W_PHY2_HI_BASE 8'h30
`define PPL_W_PORT_BASE 8'h40
`define PPL_W_STEP 8'h02
`define PPL_W_PM 8'h50

// ------------------------------------------------------------
// Configuration space offsets
// ------------------------------------------------------------
`define PPL_OFS_PM_CAP 8'h40
`define PPL_OFS_PM_CTL 8'h44
`define PPL_OFS_LINK_PHY 8'h78
`define PPL_OFS_PHY2 8'h7C
`define PPL_OFS_TL_CTL 8'h8C
`define PPL_OFS_PHY3 8'h90
`define PPL_OFS_DEEMPH 8'hF0

// ------------------------------------------------------------
// Source bit positions inside preload words
// ------------------------------------------------------------
`define PPL_S_PHY2_HI 4'h0
`define PPL_S_PHY2_LO 4'h0
`define PPL_S_PHY3 4'h5
`define PPL_S_DEEMPH 4'hC
`define PPL_S_COMP_DET 4'hD
`define PPL_S_CHG_CNT 4'hE
`define PPL_S_NO_SRST 4'h0
`define PPL_S_AUX_CUR 4'h1

// ------------------------------------------------------------
// Destination bit positions inside configuration words
// ------------------------------------------------------------
`define PPL_D_PHY2_HI 5'h10
`define PPL_D_PHY2_LO 5'h08
`define PPL_D_PHY3 5'h00
`define PPL_D_DEEMPH 5'h06
`define PPL_D_COMP_DET 5'h0B
`define PPL_D_CHG_CNT 5'h08
`define PPL_D_NO_SRST 5'h03
`define PPL_D_AUX_CUR 5'h16
`define PPL_D_D1_SUP 5'h19

// ------------------------------------------------------------
// Reset defaults
// ------------------------------------------------------------
`define PPL_RST_PHY2_HI 15'h0000
`define PPL_RST_PHY2_LO 5'h00
`define PPL_RST_PHY3 7'h00
`define PPL_RST_BIT 1'h0
`define PPL_RST_CHG_CNT 2'h0
`define PPL_RST_AUX_CUR 3'h0
`define PPL_RD_ZERO 32'h0000_0000

`endif

// [hw/ppl_loader.sv]
// Preload loader top: takes configuration memory words, fills per-port fields, serves reads.
// Assumes the memory reader delivers words on this clock and raises LOAD_DONE with or after the last.
`timescale 1ns/1ps
`include "ppl_cfg.svh"

// Operation
// - Ports 2..5: words 34h..3Ah bits 14:0 go to tuning register bits 30:16.
// - Ports 0..5: words 0x40..0x4A bits 4:0 go to tuning register bits 12:8.
// - Same words bits 11:5 go to third tuning register bits 6:0.
// - Ports 1..5 only: word bit 12 becomes deemphasis_select bit 6.
// - Every port: word bit 13 becomes link_phy_control bit 11, compliance to detect.
// - Every port: word bits 15:14 become data count select bits 9:8 at 8Ch.
// - Word 0x50 bit 0 becomes port 0 no-soft-reset, power_mgmt_control_status bit 3.
// - Word 0x50 bits 3:1 become port 0 auxiliary current, power_mgmt_capability bits 24:22.
// - Port 0 capability bit 25 always reads as one, advertising D1 support.
// - Ports 0 and 1: words 30h, 32h bits 14:0 go to bits 30:16.
module ppl_loader (
  // Clock, reset and enable
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CE,
  // Preload words from the configuration memory reader
  input wire logic WORD_VALID,
  input wire logic [7:0] WORD_ADDR,
  input wire logic [15:0] WORD_DATA,
  input wire logic LOAD_DONE,
  // Configuration read port
  input wire logic CFG_RD_EN,
  input wire logic [2:0] CFG_RD_PORT,
  input wire logic [7:0] CFG_RD_OFFSET,
  output logic CFG_RD_VALID,
  output logic [31:0] CFG_RD_DATA,
  // Loaded state
  output logic CFG_READY,
  output ppl_pkg::ppl_port_fields_t [5:0] PORT_FIELDS,
  output ppl_pkg::ppl_pm_fields_t PM_FIELDS
);

  // ------------------------------------------------------------
  // Load phase
  // ------------------------------------------------------------
  ppl_pkg::ppl_state_t state_q;
  ppl_pkg::ppl_state_t state_d;

  wire logic loading = (state_q == ppl_pkg::PPL_LOADING);
  wire logic word_wr = CE && loading && WORD_VALID;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ppl_pkg::PPL_LOADING: begin
        if (CE && LOAD_DONE) begin
          state_d = ppl_pkg::PPL_READY;
        end
      end
      ppl_pkg::PPL_READY: begin
        state_d = ppl_pkg::PPL_READY;
      end
      default: begin
        state_d = ppl_pkg::PPL_LOADING;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_q <= ppl_pkg::PPL_LOADING;
    end else begin
      state_q <= state_d;
    end
  end

  assign CFG_READY = (state_q == ppl_pkg::PPL_READY);

  // ------------------------------------------------------------
  // Per-port field stores
  // ------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < `PPL_NUM_PORTS; gp++) begin : g_port
      ppl_port_store #(
        .PORT(3'(gp))
      ) u_store (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .wr(word_wr),
        .addr(WORD_ADDR),
        .data(WORD_DATA),
        .fields(PORT_FIELDS[gp])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Power management word of port 0
  // ------------------------------------------------------------
  wire logic hit_pm = word_wr && (WORD_ADDR == `PPL_W_PM);
  ppl_pkg::ppl_pm_fields_t pm_q;
  ppl_pkg::ppl_pm_fields_t pm_d;

  always_comb begin
    pm_d = pm_q;
    if (hit_pm) begin
      pm_d.no_soft_reset = WORD_DATA[`PPL_S_NO_SRST];
      pm_d.aux_current = WORD_DATA[`PPL_S_AUX_CUR +: 3];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pm_q <= {`PPL_RST_BIT, `PPL_RST_AUX_CUR};
    end else begin
      pm_q <= pm_d;
    end
  end

  assign PM_FIELDS = pm_q;

  // ------------------------------------------------------------
  // Read word assembly
  // ------------------------------------------------------------
  // Bits that belong to other blocks read as zero here; the switch core merges its own.
  wire logic port_ok = (CFG_RD_PORT < `PPL_NUM_PORTS);
  wire logic port0 = (CFG_RD_PORT == 3'h0);
  wire ppl_pkg::ppl_port_fields_t pf = port_ok ? PORT_FIELDS[CFG_RD_PORT] : '0;
  logic [31:0] rd_word;

  always_comb begin
    rd_word = `PPL_RD_ZERO;
    if (!port_ok) begin
      rd_word = `PPL_RD_ZERO;
    end else if (CFG_RD_OFFSET == `PPL_OFS_PHY2) begin
      rd_word[`PPL_D_PHY2_HI +: 15] = pf.phy2_hi;
      rd_word[`PPL_D_PHY2_LO +: 5] = pf.phy2_lo;
    end else if (CFG_RD_OFFSET == `PPL_OFS_PHY3) begin
      rd_word[`PPL_D_PHY3 +: 7] = pf.phy3;
    end else if (CFG_RD_OFFSET == `PPL_OFS_DEEMPH) begin
      rd_word[`PPL_D_DEEMPH] = pf.deemph;
    end else if (CFG_RD_OFFSET == `PPL_OFS_LINK_PHY) begin
      rd_word[`PPL_D_COMP_DET] = pf.comp_det;
    end else if (CFG_RD_OFFSET == `PPL_OFS_TL_CTL) begin
      rd_word[`PPL_D_CHG_CNT +: 2] = pf.change_data_count_select;
    end else if (port0 && CFG_RD_OFFSET == `PPL_OFS_PM_CTL) begin
      rd_word[`PPL_D_NO_SRST] = pm_q.no_soft_reset;
    end else if (port0 && CFG_RD_OFFSET == `PPL_OFS_PM_CAP) begin
      rd_word[`PPL_D_AUX_CUR +: 3] = pm_q.aux_current;
      rd_word[`PPL_D_D1_SUP] = 1'h1;
    end else begin
      rd_word = `PPL_RD_ZERO;
    end
  end

  wire logic rd_take = CE && CFG_READY && CFG_RD_EN;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      CFG_RD_VALID <= 1'h0;
      CFG_RD_DATA <= `PPL_RD_ZERO;
    end else if (CE) begin
      CFG_RD_VALID <= rd_take;
      if (rd_take) begin
        CFG_RD_DATA <= rd_word;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_nsr;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    hit_pm |=> pm_q.no_soft_reset == $past(WORD_DATA[0]);
  endproperty
  a_nsr: assert property (p_nsr) else $error("no soft reset bit not loaded");

  property p_aux;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    hit_pm |=> pm_q.aux_current == $past(WORD_DATA[3:1]);
  endproperty
  a_aux: assert property (p_aux) else $error("aux current not loaded");

  property p_d1;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    rd_take && port0 && CFG_RD_OFFSET == `PPL_OFS_PM_CAP |=> CFG_RD_VALID && CFG_RD_DATA[25];
  endproperty
  a_d1: assert property (p_d1) else $error("D1 support bit not read as one");

  property p_no_early_read;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    !CFG_READY |=> !CFG_RD_VALID;
  endproperty
  a_no_early_read: assert property (p_no_early_read) else $error("read answered during load");

  property p_frozen_after_load;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    CFG_READY |=> $stable(pm_q) && $stable(PORT_FIELDS) && CFG_READY;
  endproperty
  a_frozen_after_load: assert property (p_frozen_after_load) else $error("fields moved after load");

  property p_phy2_read;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    rd_take && port_ok && CFG_RD_OFFSET == `PPL_OFS_PHY2
      |=> CFG_RD_DATA[30:16] == $past(pf.phy2_hi) && CFG_RD_DATA[31] == 1'b0;
  endproperty
  a_phy2_read: assert property (p_phy2_read) else $error("tuning word read back wrong");

endmodule

// [hw/ppl_pkg.sv]
// Types shared by the preload loader and its per-port field store.
// Assumes ppl_cfg.svh supplies every figure; this package holds only types.
package ppl_pkg;

  // ------------------------------------------------------------
  // Field groups
  // ------------------------------------------------------------
  typedef struct packed {
    logic [14:0] phy2_hi;
    logic [4:0] phy2_lo;
    logic [6:0] phy3;
    logic deemph;
    logic comp_det;
    logic [1:0] change_data_count_select;
  } ppl_port_fields_t;

  typedef struct packed {
    logic no_soft_reset;
    logic [2:0] aux_current;
  } ppl_pm_fields_t;

  typedef enum logic [0:0] {
    PPL_LOADING,
    PPL_READY
  } ppl_state_t;

endpackage

// [hw/ppl_port_store.sv]
// Field store of one switch port, filled from the preload words that belong to it.
// Assumes the strobe is already qualified by the loading phase and the clock enable.
`timescale 1ns/1ps
`include "ppl_cfg.svh"

module ppl_port_store #(
  parameter logic [2:0] PORT = 3'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Preload word
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [15:0] data,
  // Stored fields
  output ppl_pkg::ppl_port_fields_t fields
);

  // ------------------------------------------------------------
  // Word decode
  // ------------------------------------------------------------
  function automatic logic word_hit(input logic [7:0] a, input logic [7:0] base);
    word_hit = (a == 8'(base + `PPL_W_STEP * {5'h00, PORT}));
  endfunction

  wire logic hit_hi = wr && word_hit(addr, `PPL_W_PHY2_HI_BASE);
  wire logic hit_port = wr && word_hit(addr, `PPL_W_PORT_BASE);
  // Port 0 has no de-emphasis control, so its word bit is dropped.
  wire logic has_deemph = (PORT != 3'h0);

  ppl_pkg::ppl_port_fields_t fields_q;
  ppl_pkg::ppl_port_fields_t fields_d;

  always_comb begin
    fields_d = fields_q;
    if (hit_hi) begin
      fields_d.phy2_hi = data[`PPL_S_PHY2_HI +: 15];
    end
    if (hit_port) begin
      fields_d.phy2_lo = data[`PPL_S_PHY2_LO +: 5];
      fields_d.phy3 = data[`PPL_S_PHY3 +: 7];
      if (has_deemph) begin
        fields_d.deemph = data[`PPL_S_DEEMPH];
      end
      fields_d.comp_det = data[`PPL_S_COMP_DET];
      fields_d.change_data_count_select = data[`PPL_S_CHG_CNT +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fields_q <= {`PPL_RST_PHY2_HI, `PPL_RST_PHY2_LO, `PPL_RST_PHY3, `PPL_RST_BIT,
                   `PPL_RST_BIT, `PPL_RST_CHG_CNT};
    end else begin
      fields_q <= fields_d;
    end
  end

  assign fields = fields_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_phy2_hi;
    @(posedge clk) disable iff (rst)
    hit_hi |=> fields_q.phy2_hi == $past(data[14:0]);
  endproperty
  a_phy2_hi: assert property (p_phy2_hi) else $error("upper tuning bits not loaded");

  property p_phy2_lo;
    @(posedge clk) disable iff (rst)
    hit_port |=> fields_q.phy2_lo == $past(data[4:0]) && fields_q.phy3 == $past(data[11:5]);
  endproperty
  a_phy2_lo: assert property (p_phy2_lo) else $error("lower tuning bits not loaded");

  property p_deemph;
    @(posedge clk) disable iff (rst)
    hit_port |=> fields_q.deemph == (has_deemph ? $past(data[12]) : $past(fields_q.deemph));
  endproperty
  a_deemph: assert property (p_deemph) else $error("de-emphasis bit wrong");

  property p_comp_cnt;
    @(posedge clk) disable iff (rst)
    hit_port |=> fields_q.comp_det == $past(data[13])
      && fields_q.change_data_count_select == $past(data[15:14]);
  endproperty
  a_comp_cnt: assert property (p_comp_cnt) else $error("compliance or count bits wrong");

  property p_hold;
    @(posedge clk) disable iff (rst)
    !hit_hi && !hit_port |=> $stable(fields_q);
  endproperty
  a_hold: assert property (p_hold) else $error("field changed without its word");

endmodule

// [testbench/ppl_loader_tb.sv]
// Self-checking bench of the preload loader, fed by the behavioural configuration memory.
// Assumes the design files and the memory model are compiled first.
`timescale 1ns/1ps

module ppl_loader_tb;
  logic clk_sys, sys_rst, tog, start, slow, ld, v;
  logic ce = 1'b1;
  logic word_valid, load_done, cfg_rd_en, cfg_rd_valid, cfg_ready, mem_busy;
  logic [7:0] word_addr, cfg_rd_offset;
  logic [15:0] word_data;
  logic [2:0] cfg_rd_port;
  logic [31:0] cfg_rd_data, d;
  logic [255:0][15:0] rom, gold;
  ppl_pkg::ppl_port_fields_t [5:0] port_fields;
  ppl_pkg::ppl_pm_fields_t pm_fields;
  int error_cnt, num_checks, cycles;
  typedef struct {logic [2:0] port; logic [7:0] ofs; logic [31:0] exp;} ppl_row_t;
  ppl_row_t rows[72];
  localparam logic [7:0] OFS [9] = '{8'h40, 8'h44, 8'h78, 8'h7C, 8'h8C, 8'h90, 8'hF0,
    8'h00, 8'hFC};

  ppl_loader dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CE(ce), .WORD_VALID(word_valid),
    .WORD_ADDR(word_addr), .WORD_DATA(word_data), .LOAD_DONE(load_done),
    .CFG_RD_EN(cfg_rd_en), .CFG_RD_PORT(cfg_rd_port), .CFG_RD_OFFSET(cfg_rd_offset),
    .CFG_RD_VALID(cfg_rd_valid), .CFG_RD_DATA(cfg_rd_data), .CFG_READY(cfg_ready),
    .PORT_FIELDS(port_fields), .PM_FIELDS(pm_fields));
  ppl_mem_model mem (.clk(clk_sys), .rst(sys_rst), .ce(ce), .start(start), .slow(slow),
    .rom(rom), .word_valid(word_valid), .word_addr(word_addr), .word_data(word_data),
    .load_done(load_done), .busy(mem_busy));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    ce <= tog ? ~ce : 1'b1;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [31:0] expv(input logic [2:0] p, input logic [7:0] o);
    logic [15:0] w2, w4, pm;
    w2 = gold[8'h30 + {4'h0, p, 1'b0}];
    w4 = gold[8'h40 + {4'h0, p, 1'b0}];
    pm = gold[8'h50];
    expv = 32'h0000_0000;
    if (p > 3'h5) return expv;
    case (o)
      8'h7C: expv = {1'b0, w2[14:0], 3'h0, w4[4:0], 8'h00};
      8'h90: expv = {25'h0, w4[11:5]};
      8'hF0: expv = {25'h0, w4[12] & (p != 3'h0), 6'h00};
      8'h78: expv = {20'h0, w4[13], 11'h000};
      8'h8C: expv = {22'h0, w4[15:14], 8'h00};
      8'h44: expv = (p == 3'h0) ? {28'h0, pm[0], 3'h0} : 32'h0000_0000;
      8'h40: expv = (p == 3'h0) ? {6'h00, 1'b1, pm[3:1], 22'h0} : 32'h0000_0000;
      default: expv = 32'h0000_0000;
    endcase
  endfunction
  task automatic rd(input logic [2:0] p, input logic [7:0] o);
    @(posedge clk_sys);
    cfg_rd_en <= 1'b1;
    cfg_rd_port <= p;
    cfg_rd_offset <= o;
    @(posedge clk_sys);
    cfg_rd_en <= 1'b0;
    #1;
    v = cfg_rd_valid;
    d = cfg_rd_data;
  endtask
  // In a real load, reads are requested until LOAD_DONE is seen; none may be answered before it ends.
  task automatic load(input logic s, input int k, input logic real_load);
    for (int i = 0; i < 256; i++) rom[i] = 16'(i * 32'h9E37 + k * 32'h3B1D);
    rom[8'h50][4] = 1'b0;
    if (real_load) gold = rom;
    ld = 1'b0;
    @(posedge clk_sys);
    slow <= s;
    start <= 1'b1;
    for (int n = 0; n < 200 && (n == 0 || cfg_ready !== 1'b1 || mem_busy !== 1'b0); n++) begin
      @(posedge clk_sys);
      start <= 1'b0;
      cfg_rd_en <= !ld && real_load;
      #1;
      ld = ld | (load_done === 1'b1);
      if (real_load) check({31'h0, cfg_rd_valid}, 32'h0);
    end
  endtask
  task automatic check_fields();
    logic [15:0] w2, w4;
    for (int p = 0; p < 6; p++) begin
      w2 = gold[8'h30 + 2 * p];
      w4 = gold[8'h40 + 2 * p];
      check({1'b0, port_fields[p]}, {1'b0, w2[14:0], w4[4:0], w4[11:5],
        w4[12] & (p != 0), w4[13], w4[15:14]});
    end
    check({28'h0, pm_fields}, {28'h0, gold[8'h50][0], gold[8'h50][3:1]});
  endtask
  task automatic run_rows(input string name);
    for (int i = 0; i < 72; i++) rows[i] = '{3'(i / 9), OFS[i % 9], expv(3'(i / 9), OFS[i % 9])};
    foreach (rows[i]) begin
      rd(rows[i].port, rows[i].ofs);
      check({31'h0, v}, 32'h1);
      check(d, rows[i].exp);
    end
    $display("test %s done", name);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {sys_rst, tog, start, slow, cfg_rd_en} = 5'b10000;
    {cfg_rd_port, cfg_rd_offset} = '0;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    check({1'b0, port_fields[3]}, 32'h0);
    tog <= 1'b1;
    load(1'b0, 0, 1'b1);
    tog <= 1'b0;
    @(posedge clk_sys);
    #1;
    check_fields();
    run_rows("stalled_load");
    load(1'b0, 2, 1'b0);
    check_fields();
    run_rows("late_words");
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    check({cfg_ready, cfg_rd_data[30:0]}, 32'h0);
    load(1'b1, 1, 1'b1);
    run_rows("slow_load");
    // Back to back reads: the second request follows the first with no idle edge.
    @(posedge clk_sys);
    cfg_rd_en <= 1'b1;
    cfg_rd_port <= 3'h0;
    cfg_rd_offset <= 8'h7C;
    @(posedge clk_sys);
    cfg_rd_port <= 3'h5;
    cfg_rd_offset <= 8'h90;
    #1;
    check({31'h0, cfg_rd_valid}, 32'h1);
    check(cfg_rd_data, expv(3'h0, 8'h7C));
    @(posedge clk_sys);
    cfg_rd_en <= 1'b0;
    #1;
    check({31'h0, cfg_rd_valid}, 32'h1);
    check(cfg_rd_data, expv(3'h5, 8'h90));
    @(posedge clk_sys);
    #1;
    check({31'h0, cfg_rd_valid}, 32'h0);
    check(cfg_rd_data, expv(3'h5, 8'h90));
    $display("test back_to_back done");
    end_of_test();
  end
endmodule

// [testbench/ppl_mem_model.sv]
// Behavioural configuration memory that walks word addresses 2Eh to 50h in steps of two.
// Assumes the loader takes a word on an edge with ce high, so each word is held until then.
`timescale 1ns/1ps

module ppl_mem_model (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic slow,
  // Memory contents
  input wire logic [255:0][15:0] rom,
  // Word stream
  output logic word_valid,
  output logic [7:0] word_addr,
  output logic [15:0] word_data,
  output logic load_done,
  output logic busy
);
  logic [7:0] a_q;
  wire logic [7:0] na = word_valid ? a_q + 8'h02 : a_q;

  // ------------------------------------------------------------
  // Word walk
  // ------------------------------------------------------------
  // Released lines show the inverse of their last value, so a stale copy is never seen.
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      word_valid <= 1'b0;
      load_done <= 1'b0;
      a_q <= 8'h00;
    end else if (start && !busy) begin
      busy <= 1'b1;
      a_q <= 8'h2E;
      word_valid <= 1'b1;
      word_addr <= 8'h2E;
      word_data <= rom[8'h2E];
    end else if (busy && ce) begin
      a_q <= na;
      if (word_valid && (load_done || slow)) begin
        busy <= !load_done;
        load_done <= 1'b0;
        word_valid <= 1'b0;
        word_addr <= ~word_addr;
        word_data <= ~word_data;
      end else begin
        word_valid <= 1'b1;
        word_addr <= na;
        word_data <= rom[na];
        load_done <= (na == 8'h50);
      end
    end
  end
endmodule
